// ==== logic/homing_sequencer.sv ====
// Homing sequencer: method decode, switch and index search, dimension setting
`timescale 1ns/100ps
`default_nettype none
`include "homing_sequencer_consts.svh"

// Behaviour
// - Code 17 homes on negative limit, then moves set distance past edge, no index.
// - Edge methods: search speed to switch, clearance to edge, clearance over distance.
// - Codes 27..30 use reference switch with distance-to-edge, direction and edge vary.
// - Passing through reference window at search speed returns at clearance speed.
// - Codes 1..14 approach switch then search first index pulse after edge as reference.
// - Code 2 homes on positive limit then moves to first index after edge.
// - Codes 11..14 use reference switch then first index; direction and edge vary.
// - Index methods end with clearance-speed travel stopping at detected index pulse.
// - Codes 33 and 34 home directly on index pulse, one per direction.
// - Code 35 selects dimension setting, which performs no movement.
// - Dimension setting overwrites motor position with set value, redefining zero.
// - Dimension setting accepted only at standstill; master requests only then.
// - Dimension setting keeps outstanding position deviation for the controller.
// - Dimension set position resets to zero and is writable over fieldbus.
// - Position controller setpoint readable only, signed 32 bits.
// - Codes 17..30 home without index search; code bits give switch and direction.
// - After successful homing, home position value loads as current position.
// - Edge-to-reference distance defaults to 200, minimum 1.
module homing_sequencer
  import homing_sequencer_pkg::*;
(
  // Clock and reset
  input  wire logic                             clock,
  input  wire logic                             rstn,
  // Fieldbus parameter access
  input  wire homing_sequencer_pkg::reg_req_t   regReq,
  output logic [31:0]                           regRdata,
  output logic                                  regAck,
  output logic                                  regErr,
  // Field inputs, asynchronous
  input  wire homing_sequencer_pkg::field_in_t  fieldIn,
  // Position controller side
  input  wire logic                             standstill,
  input  wire logic signed [31:0]               actualPosition,
  input  wire logic signed [31:0]               controllerSetpoint,
  // Motion command to the profile generator
  output homing_sequencer_pkg::motion_t         motion,
  output logic                                  positionLoad,
  output logic signed [31:0]                    positionLoadValue,
  output logic signed [31:0]                    setpointShift,
  // Status
  output logic                                  referenceValid,
  output logic                                  homingBusy
);
  import homing_sequencer_pkg::*;

  typedef enum logic [2:0] {
    IDLE,
    SEEK_SWITCH,
    RETURN_AREA,
    SEEK_EDGE,
    TRAVEL_DIST,
    SEEK_INDEX,
    DONE
  } state_t;

  // Two-flop synchronisers on field inputs
  field_in_t syncA;
  field_in_t syncB;
  logic      prevRef;
  logic      prevIndex;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      syncA     <= '0;
      syncB     <= '0;
      prevRef   <= 1'b0;
      prevIndex <= 1'b0;
    end else begin
      syncA     <= fieldIn;
      syncB     <= syncA;
      prevRef   <= syncB.refSw;
      prevIndex <= syncB.indexPulse;
    end
  end

  // Field levels after the second stage; nothing reads the first stage
  // Edge history resets low like the synchronisers, so an index pin high at reset gives one rise after reset
  wire limNegLvl = syncB.limNeg;
  wire limPosLvl = syncB.limPos;
  wire refLvl    = syncB.refSw;
  wire indexLvl  = syncB.indexPulse;

  // Parameter registers
  logic [7:0]         methodSelect;
  logic signed [31:0] dimensionSetPosition;
  logic [31:0]        edgeDistance;
  logic signed [31:0] homePositionValue;
  logic               rejected;

  wire hitMethod = regReq.addr == `OFS_HOMING_METHOD_SELECT;
  wire hitDimSet = regReq.addr == `OFS_DIMENSION_SET_POSITION;
  wire hitDist   = regReq.addr == `OFS_EDGE_TO_REFERENCE_DISTANCE;
  wire hitHome   = regReq.addr == `OFS_HOME_POSITION_VALUE;
  wire hitCtrl   = regReq.addr == `OFS_HOMING_CONTROL;
  wire hitStat   = regReq.addr == `OFS_HOMING_STATUS;
  wire hitSetp   = regReq.addr == `OFS_POSITION_SETPOINT_READBACK;
  wire hitAny    = hitMethod | hitDimSet | hitDist | hitHome | hitCtrl | hitStat | hitSetp;
  wire badWrite  = regReq.wr & (hitSetp | hitStat | !hitAny);
  wire startReq  = regReq.wr & hitCtrl & regReq.wdata[`CTRL_START_BIT];
  wire abortReq  = regReq.wr & hitCtrl & regReq.wdata[`CTRL_ABORT_BIT];
  // Values below the minimum are clamped, not refused
  wire [31:0] distWrite = ($signed(regReq.wdata) < $signed(`MIN_EDGE_TO_REFERENCE_DISTANCE))
                          ? `MIN_EDGE_TO_REFERENCE_DISTANCE : regReq.wdata;
  // Write strobes per parameter
  wire wrMethod = regReq.wr & hitMethod;
  wire wrDimSet = regReq.wr & hitDimSet;
  wire wrDist   = regReq.wr & hitDist;
  wire wrHome   = regReq.wr & hitHome;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      methodSelect         <= 8'h00;
      dimensionSetPosition <= `RST_DIMENSION_SET_POSITION;
      edgeDistance         <= `RST_EDGE_TO_REFERENCE_DISTANCE;
      homePositionValue    <= `RST_HOME_POSITION_VALUE;
    end else begin
      if (wrMethod)
        methodSelect <= regReq.wdata[7:0];
      if (wrDimSet)
        dimensionSetPosition <= regReq.wdata;
      if (wrDist)
        edgeDistance <= distWrite;
      if (wrHome)
        homePositionValue <= regReq.wdata;
    end
  end

  // Method decode
  function automatic logic inRange(input logic [7:0] m, input logic [7:0] lo,
                                   input logic [7:0] hi);
    inRange = (m >= lo) && (m <= hi);
  endfunction

  wire isIndexSw   = inRange(methodSelect, `M_INDEX_FIRST, `M_INDEX_LAST);
  wire isNoIndex   = inRange(methodSelect, `M_NOINDEX_FIRST, `M_NOINDEX_LAST);
  wire isIndexOnly = (methodSelect == `M_INDEX_ONLY_NEG) ||
                     (methodSelect == `M_INDEX_ONLY_POS);
  wire isDimSet    = methodSelect == `M_DIMENSION_SET;
  wire supported   = isIndexSw | isNoIndex | isIndexOnly | isDimSet;
  wire isRefIndex  = inRange(methodSelect, `M_REF_INDEX_FIRST, `M_INDEX_LAST);
  wire isRefNoIdx  = inRange(methodSelect, `M_REF_NOINDEX_FIRST, `M_NOINDEX_LAST);
  wire useRefSw    = isRefIndex | isRefNoIdx;
  // Code bit 0 picks start direction and edge side within a family; codes 18..26 all start positive
  wire codeOdd     = methodSelect[0];
  wire limitNeg    = (methodSelect == `M_NOINDEX_FIRST) | (isIndexSw & !isRefIndex &
                     codeOdd);
  wire limitDirPos = !limitNeg;
  wire refDirPos   = !codeOdd;
  wire indexDirPos = methodSelect == `M_INDEX_ONLY_POS;
  wire startDir    = useRefSw ? refDirPos : (isIndexOnly ? indexDirPos : limitDirPos);

  // Sequencer
  state_t             state;
  logic               dirPos;
  logic               seenRef;
  logic signed [31:0] edgePos;
  logic               useLimPos;

  // Distance covered since the edge, measured along the travel direction
  function automatic logic signed [31:0] travelled(input logic fwd,
                                                   input logic signed [31:0] now,
                                                   input logic signed [31:0] from);
    travelled = fwd ? now - from : from - now;
  endfunction

  // Limit latched at start: the axis turns round while still on it
  wire switchLevel = useRefSw  ? refLvl :
                     useLimPos ? limPosLvl : limNegLvl;
  wire refFell     = prevRef & !refLvl;
  wire indexRise   = indexLvl & !prevIndex;
  wire distReached = travelled(dirPos, actualPosition, edgePos) >= $signed(edgeDistance);
  wire atIdle      = state == IDLE;
  wire atDone      = state == DONE;
  wire dimAccept   = startReq & isDimSet & standstill;
  wire moveStart   = startReq & supported & !isDimSet & atIdle;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state    <= IDLE;
      dirPos   <= 1'b0;
      seenRef  <= 1'b0;
      edgePos   <= '0;
      useLimPos <= 1'b0;
    end else if (abortReq) begin
      state <= IDLE;
    end else begin
      case (state)
        IDLE: begin
          if (moveStart) begin
            dirPos  <= startDir;
            useLimPos <= limitDirPos;
            seenRef <= 1'b0;
            state   <= isIndexOnly ? SEEK_INDEX : SEEK_SWITCH;
          end
        end
        SEEK_SWITCH: begin
          if (useRefSw) begin
            seenRef <= refLvl;
            if (seenRef & refFell) begin
              // Window seen for one sample only: search speed overran it
              dirPos <= !dirPos;
              state  <= RETURN_AREA;
            end else if (seenRef & refLvl) begin
              state <= SEEK_EDGE;
            end
          end else if (switchLevel) begin
            // Limit reached: turn round and leave it at clearance speed
            dirPos <= !dirPos;
            state  <= SEEK_EDGE;
          end
        end
        RETURN_AREA: begin
          if (refLvl)
            state <= SEEK_EDGE;
        end
        SEEK_EDGE: begin
          if (!switchLevel) begin
            edgePos <= actualPosition;
            state   <= isNoIndex ? TRAVEL_DIST : SEEK_INDEX;
          end
        end
        TRAVEL_DIST: begin
          if (distReached)
            state <= DONE;
        end
        SEEK_INDEX: begin
          if (indexRise)
            state <= DONE;
        end
        // One cycle here makes the load and flag pulse once
        DONE: state <= IDLE;
        default: state <= IDLE;
      endcase
    end
  end

  // Motion command
  always_comb begin
    motion.active = 1'b1;
    motion.dirPos = dirPos;
    case (state)
      SEEK_SWITCH: motion.speed = SPEED_SEARCH;
      RETURN_AREA: motion.speed = SPEED_CLEAR;
      SEEK_EDGE:   motion.speed = SPEED_CLEAR;
      TRAVEL_DIST: motion.speed = SPEED_CLEAR;
      SEEK_INDEX:  motion.speed = SPEED_CLEAR;
      default: begin
        motion.active = 1'b0;
        motion.speed  = SPEED_STOP;
      end
    endcase
  end

  // Refusal flag, refreshed by every start request
  wire refuse = !supported | (isDimSet & !standstill);

  always_ff @(posedge clock) begin
    if (!rstn)
      rejected <= 1'b0;
    else if (startReq)
      rejected <= refuse;
  end

  // Position loading
  always_ff @(posedge clock) begin
    if (!rstn) begin
      positionLoad      <= 1'b0;
      positionLoadValue <= '0;
      setpointShift     <= '0;
    end else begin
      positionLoad <= 1'b0;
      if (atDone) begin
        positionLoad      <= 1'b1;
        positionLoadValue <= homePositionValue;
        setpointShift     <= homePositionValue - actualPosition;
      end else if (dimAccept) begin
        positionLoad      <= 1'b1;
        positionLoadValue <= dimensionSetPosition;
        // Setpoint moves by same amount, so deviation survives
        setpointShift     <= dimensionSetPosition - actualPosition;
      end
    end
  end

  // Reference flag; a set in the same cycle as a clear wins
  wire setValid   = atDone | dimAccept;
  wire clearValid = moveStart | abortReq;

  always_ff @(posedge clock) begin
    if (!rstn)
      referenceValid <= 1'b0;
    else if (setValid)
      referenceValid <= 1'b1;
    else if (clearValid)
      referenceValid <= 1'b0;
  end

  assign homingBusy = !atIdle;

  // Status bits placed by their defined positions
  logic [31:0] statusWord;
  always_comb begin
    statusWord                   = 32'h0000_0000;
    statusWord[`STAT_VALID_BIT]  = referenceValid;
    statusWord[`STAT_BUSY_BIT]   = homingBusy;
    statusWord[`STAT_REJECT_BIT] = rejected;
  end

  // Address hits are one-hot, so the read word is an OR of gated fields
  wire [31:0] readWord = ({32{hitMethod}} & {24'h00, methodSelect}) |
                         ({32{hitDimSet}} & dimensionSetPosition) |
                         ({32{hitDist}}   & edgeDistance) |
                         ({32{hitHome}}   & homePositionValue) |
                         ({32{hitStat}}   & statusWord) |
                         ({32{hitSetp}}   & controllerSetpoint);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      regRdata <= '0;
      regAck   <= 1'b0;
      regErr   <= 1'b0;
    end else begin
      regAck <= (regReq.rd | regReq.wr) & hitAny & !badWrite;
      regErr <= (regReq.rd & !hitAny) | badWrite;
      if (regReq.rd)
        regRdata <= readWord;
    end
  end
endmodule
`default_nettype wire

// ==== logic/homing_sequencer_consts.svh ====
// Register offsets, method codes, reset values and field positions of the homing sequencer
`ifndef HOMING_SEQUENCER_CONSTS_SVH
`define HOMING_SEQUENCER_CONSTS_SVH
`define OFS_DIMENSION_SET_POSITION      16'h1B2C
`define OFS_POSITION_SETPOINT_READBACK  16'h1E18
`define OFS_HOMING_METHOD_SELECT        16'h1B00
`define OFS_EDGE_TO_REFERENCE_DISTANCE  16'h1B04
`define OFS_HOME_POSITION_VALUE         16'h1B08
`define OFS_HOMING_CONTROL              16'h1B0C
`define OFS_HOMING_STATUS               16'h1B10
`define RST_DIMENSION_SET_POSITION      32'h0000_0000
`define RST_EDGE_TO_REFERENCE_DISTANCE  32'h0000_00C8
`define RST_HOME_POSITION_VALUE         32'h0000_0000
`define MIN_EDGE_TO_REFERENCE_DISTANCE  32'h0000_0001
`define M_LIM_POS_INDEX                 8'h02
`define M_INDEX_FIRST                   8'h01
`define M_INDEX_LAST                    8'h0E
`define M_REF_INDEX_FIRST               8'h0B
`define M_NOINDEX_FIRST                 8'h11
`define M_NOINDEX_LAST                  8'h1E
`define M_REF_NOINDEX_FIRST             8'h1B
`define M_INDEX_ONLY_NEG                8'h21
`define M_INDEX_ONLY_POS                8'h22
`define M_DIMENSION_SET                 8'h23
`define CTRL_START_BIT                  0
`define CTRL_ABORT_BIT                  1
`define STAT_VALID_BIT                  0
`define STAT_BUSY_BIT                   1
`define STAT_REJECT_BIT                 2
`endif

// ==== logic/homing_sequencer_pkg.sv ====
// Types shared by the homing sequencer
package homing_sequencer_pkg;
  typedef enum logic [1:0] {
    SPEED_STOP,
    SPEED_SEARCH,
    SPEED_CLEAR
  } speed_t;

  typedef struct packed {
    logic  [15:0] addr;
    logic  [31:0] wdata;
    logic         wr;
    logic         rd;
  } reg_req_t;

  typedef struct packed {
    logic          active;
    logic          dirPos;
    speed_t        speed;
  } motion_t;

  typedef struct packed {
    logic limNeg;
    logic limPos;
    logic refSw;
    logic indexPulse;
  } field_in_t;
endpackage

// ==== testbench/homing_field_model.sv ====
// Axis model: integrates the motion command and drives the field switches
`timescale 1ns/100ps
`default_nettype none
module homing_field_model
  import homing_sequencer_pkg::*;
(
  // Clock and reset
  input  wire logic                           clock,
  input  wire logic                           rstn,
  // Commands from the sequencer
  input  wire homing_sequencer_pkg::motion_t  motion,
  input  wire logic                           positionLoad,
  input  wire logic signed [31:0]             positionLoadValue,
  // Axis state
  output logic signed [31:0]                  pos,
  output homing_sequencer_pkg::field_in_t     fieldIn
);
  // Search step as wide as the reference window, so a search overruns it
  wire logic signed [31:0] step = (motion.speed == SPEED_SEARCH) ? 32'sh8 : 32'sh1;
  always_ff @(posedge clock) begin
    if (!rstn)
      pos <= 32'sh0;
    else if (positionLoad)
      pos <= positionLoadValue;
    else if (motion.active && motion.speed != SPEED_STOP)
      pos <= motion.dirPos ? pos + step : pos - step;
  end
  assign fieldIn.limNeg = pos <= -32'sh64;
  assign fieldIn.limPos = pos >= 32'sh64;
  assign fieldIn.refSw = pos >= -32'sh14 && pos <= -32'shD;
  assign fieldIn.indexPulse = pos[4:0] == 5'h00;
endmodule
`default_nettype wire

// ==== testbench/homing_sequencer_chk.sv ====
// Port assertions for the homing sequencer
`timescale 1ns/100ps
`default_nettype none
`include "homing_sequencer_consts.svh"
module homing_sequencer_chk
  import homing_sequencer_pkg::*;
(
  // Clock and reset
  input wire logic                           clock,
  input wire logic                           rstn,
  // Observed ports
  input wire homing_sequencer_pkg::reg_req_t regReq,
  input wire logic [31:0]                    regRdata,
  input wire logic                           regAck,
  input wire logic                           regErr,
  input wire logic                           standstill,
  input wire logic signed [31:0]             controllerSetpoint,
  input wire homing_sequencer_pkg::motion_t  motion,
  input wire logic                           positionLoad,
  input wire logic signed [31:0]             positionLoadValue,
  input wire logic                           referenceValid,
  input wire logic                           homingBusy
);
  logic [7:0]  method;
  logic [31:0] dimPos;
  logic [31:0] homePos;
  wire logic wrA = regReq.wr && !regReq.rd;
  wire logic ctrlWr = wrA && regReq.addr == `OFS_HOMING_CONTROL;
  wire logic startWr = ctrlWr && regReq.wdata[0] && !regReq.wdata[1] && !homingBusy;
  wire logic badCode = method == 8'h00 || (method > 8'h0E && method < 8'h11)
                       || (method > 8'h1E && method < 8'h21) || method > 8'h23;
  // Shadows of method, dimension set position and home position value, seen from the bus only
  always_ff @(posedge clock) begin
    if (!rstn) begin
      method <= 8'h00;
      dimPos <= 32'h0;
      homePos <= 32'h0;
    end else if (wrA) begin
      if (regReq.addr == `OFS_HOMING_METHOD_SELECT) method <= regReq.wdata[7:0];
      if (regReq.addr == `OFS_DIMENSION_SET_POSITION) dimPos <= regReq.wdata;
      if (regReq.addr == `OFS_HOME_POSITION_VALUE) homePos <= regReq.wdata;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence stopped; !homingBusy && !motion.active; endsequence
  rw_answer_a: assert property ((regReq.wr || regReq.rd) |=> regAck != regErr)
    else $error("access without single answer");
  ro_write_a: assert property (wrA && regReq.addr == `OFS_POSITION_SETPOINT_READBACK
    |=> regErr) else $error("setpoint write accepted");
  setpoint_read_a: assert property (regReq.rd
    && regReq.addr == `OFS_POSITION_SETPOINT_READBACK |=> regRdata == $past(controllerSetpoint))
    else $error("setpoint readback wrong");
  busy_valid_a: assert property (homingBusy |-> !referenceValid)
    else $error("valid during homing");
  dim_load_a: assert property (startWr && method == `M_DIMENSION_SET && standstill
    |=> positionLoad && positionLoadValue == dimPos && !motion.active)
    else $error("dimension setting wrong");
  dim_refuse_a: assert property (startWr && method == `M_DIMENSION_SET && !standstill
    |=> !positionLoad) else $error("dimension set while moving");
  reject_code_a: assert property (startWr && badCode |=> stopped and !positionLoad)
    else $error("bad code started");
  search_first_a: assert property (startWr && !badCode && method < 8'h1F
    |=> motion.active && motion.speed == SPEED_SEARCH) else $error("no search first");
  limit_dir_a: assert property (startWr && (method == `M_NOINDEX_FIRST
    || method == `M_LIM_POS_INDEX) |=> motion.dirPos == (method == `M_LIM_POS_INDEX))
    else $error("wrong start direction");
  home_value_a: assert property (positionLoad && method != `M_DIMENSION_SET
    |-> positionLoadValue == homePos) else $error("wrong home value");
  abort_stop_a: assert property (ctrlWr && regReq.wdata[1]
    |=> ##[0:1] stopped ##0 !referenceValid) else $error("abort not honoured");
endmodule
bind homing_sequencer homing_sequencer_chk chk (.clock(clock), .rstn(rstn), .regReq(regReq),
  .regRdata(regRdata), .regAck(regAck), .regErr(regErr), .standstill(standstill),
  .controllerSetpoint(controllerSetpoint), .motion(motion), .positionLoad(positionLoad),
  .positionLoadValue(positionLoadValue), .referenceValid(referenceValid),
  .homingBusy(homingBusy));
`default_nettype wire

// ==== testbench/test_homing_sequencer.sv ====
// Testbench for the homing sequencer
`timescale 1ns/100ps
`default_nettype none
`include "homing_sequencer_consts.svh"
module test_homing_sequencer;
  import homing_sequencer_pkg::*;
  logic               clock = 1'b0;
  logic               rstn = 1'b0;
  logic               standOk = 1'b1;
  logic               standstill = 1'b1;
  reg_req_t           regReq = '0;
  logic [31:0]        regRdata;
  logic               regAck, regErr, positionLoad, referenceValid, homingBusy;
  logic signed [31:0] pos, positionLoadValue;
  motion_t            motion;
  field_in_t          fieldIn;
  int                 errors = 0;
  int                 cmp_count = 0;
  initial forever #12.5 clock = ~clock;
  always @(negedge clock) standstill <= standOk && !motion.active;
  homing_sequencer uut (.clock(clock), .rstn(rstn), .regReq(regReq), .regRdata(regRdata),
    .regAck(regAck), .regErr(regErr), .fieldIn(fieldIn), .standstill(standstill),
    .actualPosition(pos), .controllerSetpoint(32'shFFFFFF9C), .motion(motion),
    .positionLoad(positionLoad), .positionLoadValue(positionLoadValue), .setpointShift(),
    .referenceValid(referenceValid), .homingBusy(homingBusy));
  homing_field_model axis (.clock(clock), .rstn(rstn), .motion(motion),
    .positionLoad(positionLoad), .positionLoadValue(positionLoadValue), .pos(pos),
    .fieldIn(fieldIn));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Ends on the negedge where the answer shows, so a same-cycle load is still visible
  task automatic acc(input logic [15:0] a, input logic [31:0] d, input logic w, input logic e);
    @(negedge clock);
    regReq = '{a, d, w, !w};
    @(negedge clock);
    regReq.wr = 1'b0;
    regReq.rd = 1'b0;
    check("regErr", e, regErr);
    check("regAck", !e, regAck);
  endtask
  task automatic waitLoad(input logic [31:0] exp);
    int n = 0;
    while (positionLoad !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    check("positionLoadValue", exp, positionLoadValue);
    @(negedge clock);
    check("referenceValid", 1'b1, referenceValid);
    check("homingBusy", 1'b0, homingBusy);
  endtask
  task automatic homing(input logic [7:0] m, input logic [31:0] p);
    acc(`OFS_DIMENSION_SET_POSITION, p, 1'b1, 1'b0);
    acc(`OFS_HOMING_METHOD_SELECT, 32'h23, 1'b1, 1'b0);
    acc(`OFS_HOMING_CONTROL, 32'h1, 1'b1, 1'b0);
    waitLoad(p);
    acc(`OFS_HOMING_METHOD_SELECT, {24'h0, m}, 1'b1, 1'b0);
    acc(`OFS_HOMING_CONTROL, 32'h1, 1'b1, 1'b0);
    waitLoad(32'h2A);
    $display("test method %0d done", m);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clock);
    errors++;
    summarize();
  end
  initial begin
    logic [7:0] bad [7] = '{8'h00, 8'h0F, 8'h10, 8'h1F, 8'h20, 8'h24, 8'h23};
    repeat (20) @(negedge clock);
    rstn = 1'b1;
    acc(`OFS_DIMENSION_SET_POSITION, 32'h0, 1'b0, 1'b0);
    check("dimension reset", 32'h0, regRdata);
    acc(`OFS_EDGE_TO_REFERENCE_DISTANCE, 32'h0, 1'b0, 1'b0);
    check("distance reset", 32'hC8, regRdata);
    acc(`OFS_DIMENSION_SET_POSITION, 32'hFFFF1234, 1'b1, 1'b0);
    acc(`OFS_DIMENSION_SET_POSITION, 32'h0, 1'b0, 1'b0);
    check("dimension rw", 32'hFFFF1234, regRdata);
    acc(`OFS_EDGE_TO_REFERENCE_DISTANCE, 32'h0, 1'b1, 1'b0);
    acc(`OFS_EDGE_TO_REFERENCE_DISTANCE, 32'h0, 1'b0, 1'b0);
    check("distance floor", 32'h1, regRdata);
    acc(`OFS_POSITION_SETPOINT_READBACK, 32'h5, 1'b1, 1'b1);
    acc(`OFS_POSITION_SETPOINT_READBACK, 32'h0, 1'b0, 1'b0);
    check("setpoint", 32'hFFFFFF9C, regRdata);
    acc(`OFS_HOMING_STATUS, 32'h1, 1'b1, 1'b1);
    acc(16'h1BFC, 32'h0, 1'b0, 1'b1);
    acc(`OFS_EDGE_TO_REFERENCE_DISTANCE, 32'h5, 1'b1, 1'b0);
    acc(`OFS_HOME_POSITION_VALUE, 32'h2A, 1'b1, 1'b0);
    $display("test registers done");
    standOk = 1'b0;
    foreach (bad[i]) begin
      acc(`OFS_HOMING_METHOD_SELECT, {24'h0, bad[i]}, 1'b1, 1'b0);
      acc(`OFS_HOMING_CONTROL, 32'h1, 1'b1, 1'b0);
      check("positionLoad", 1'b0, positionLoad);
      @(negedge clock);
      check("motion.active", 1'b0, motion.active);
      acc(`OFS_HOMING_STATUS, 32'h0, 1'b0, 1'b0);
      check("status reject", 1'b1, regRdata[`STAT_REJECT_BIT]);
    end
    standOk = 1'b1;
    $display("test refusals done");
    homing(8'h11, 32'h0);
    homing(8'h1B, 32'h0);
    homing(8'h02, 32'h0);
    homing(8'h0B, 32'h0);
    homing(8'h21, 32'h5);
    homing(8'h22, 32'h5);
    acc(`OFS_HOMING_METHOD_SELECT, 32'h11, 1'b1, 1'b0);
    acc(`OFS_HOMING_CONTROL, 32'h1, 1'b1, 1'b0);
    repeat (10) @(negedge clock);
    check("busy", 1'b1, homingBusy);
    check("valid while busy", 1'b0, referenceValid);
    acc(`OFS_HOMING_CONTROL, 32'h2, 1'b1, 1'b0);
    @(negedge clock);
    check("busy after abort", 1'b0, homingBusy);
    check("valid after abort", 1'b0, referenceValid);
    $display("test abort done");
    summarize();
  end
endmodule
`default_nettype wire
